// File: logic/dppi_rx.sv
// Dual-pixel panel input receiver with its clock-crossing FIFO.
`timescale 1ns/1ns
`include "dppi_defines.svh"

// ****************************************************************
// Gray-pointer FIFO between the pixel clock and the core clock
// ****************************************************************
module dppi_async_fifo #(
    parameter int WIDTH = 62,
    parameter int DEPTH = 16
) (
    // Write side
    input wire logic wr_clk_i,
    input wire logic wr_rst_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read side
    input wire logic rd_clk_i,
    input wire logic rd_rst_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [WIDTH-1:0] rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] meta;
        logic [AW:0] sync;
    } dppi_ptr_t;

    dppi_ptr_t wq_reg;
    dppi_ptr_t wq_next;
    dppi_ptr_t rq_reg;
    dppi_ptr_t rq_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic [AW:0] wbin_inc;
    logic [AW:0] rbin_inc;

    assign full = (wq_reg.gray == {~wq_reg.sync[AW:AW-1], wq_reg.sync[AW-2:0]});
    assign empty = (rq_reg.gray == rq_reg.sync);
    assign wr_ready_o = ~full;
    assign rd_valid_o = ~empty;
    assign rd_data_o = mem[rq_reg.bin[AW-1:0]];
    assign wbin_inc = wq_reg.bin + 1'b1;
    assign rbin_inc = rq_reg.bin + 1'b1;

    always_comb begin
        wq_next = wq_reg;
        wq_next.meta = rq_reg.gray;
        wq_next.sync = wq_reg.meta;
        if (wr_valid_i && !full) begin
            wq_next.bin = wbin_inc;
            wq_next.gray = wbin_inc ^ (wbin_inc >> 1);
        end
        if (wr_rst_i) begin
            wq_next = '0;
        end
    end

    always_comb begin
        rq_next = rq_reg;
        rq_next.meta = wq_reg.gray;
        rq_next.sync = rq_reg.meta;
        if (rd_ready_i && !empty) begin
            rq_next.bin = rbin_inc;
            rq_next.gray = rbin_inc ^ (rbin_inc >> 1);
        end
        if (rd_rst_i) begin
            rq_next = '0;
        end
    end

    always_ff @(posedge wr_clk_i) begin
        wq_reg <= wq_next;
        if (wr_valid_i && !full) begin
            mem[wq_reg.bin[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge rd_clk_i) begin
        rq_reg <= rq_next;
    end
endmodule

// ****************************************************************
// Receiver top
// ****************************************************************
module dppi_rx (
    // Core clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Link from the transmitter
    input wire logic pixel_clock_i,
    input wire dppi_pkg::dppi_link_t link_i,
    // Straps
    input wire logic bit_map_select_i,
    input wire logic depth_select_i,
    // Pixel pair stream
    output logic out_valid_o,
    input wire logic out_ready_i,
    output dppi_pkg::dppi_pair_t out_pair_o,
    // Status
    output logic overflow_o,
    output logic sync_fault_o
);
    import dppi_pkg::*;

    dppi_link_state_t lq_reg;
    dppi_link_state_t lq_next;
    dppi_core_state_t cq_reg;
    dppi_core_state_t cq_next;
    logic wr_ready;
    logic rd_valid;
    logic rd_ready;
    dppi_pair_t rd_data;
    logic lk_rst;
    logic de;
    logic gap_done;

    assign lk_rst = lq_reg.rst_sync;
    assign de = link_i.pixel_valid;
    assign gap_done = (lq_reg.gap >= `DPPI_FRAME_GAP);

    // ****************************************************************
    // Link domain: framing and capture on the pixel clock
    // ****************************************************************
    always_comb begin
        lq_next = lq_reg;
        lq_next.rst_meta = sys_rst_i;
        lq_next.rst_sync = lq_reg.rst_meta;
        lq_next.map_meta = bit_map_select_i;
        lq_next.map_sync = lq_reg.map_meta;
        lq_next.dep_meta = depth_select_i;
        lq_next.dep_sync = lq_reg.dep_meta;
        lq_next.hv_meta = {link_i.hsync, link_i.vsync};
        lq_next.hv_sync = lq_reg.hv_meta;
        lq_next.cap_vld = 1'b0;
        // Enable-low run length is the only timing reference.
        if (de) begin
            lq_next.gap = `DPPI_GAP_RESET;
        end else if (lq_reg.gap != `DPPI_GAP_MAX) begin
            lq_next.gap = lq_reg.gap + 1'b1;
        end
        unique case (lq_reg.st)
            LK_HUNT: begin
                // Data before the first frame gap is dropped so a frame never starts mid-way.
                if (!de && gap_done) begin
                    lq_next.st = LK_BLANK;
                end
            end
            LK_BLANK: begin
                if (de) begin
                    lq_next.st = LK_LINE;
                    lq_next.cap_vld = 1'b1;
                    lq_next.cap.line_start = 1'b1;
                    lq_next.cap.frame_start = gap_done;
                end
            end
            LK_LINE: begin
                if (de) begin
                    lq_next.cap_vld = 1'b1;
                    lq_next.cap.line_start = 1'b0;
                    lq_next.cap.frame_start = 1'b0;
                end else begin
                    lq_next.st = LK_BLANK;
                end
            end
        endcase
        if (lq_next.cap_vld) begin
            // Both lanes are taken on one edge, odd pixel in the first lane.
            lq_next.cap.first = dppi_decode_pixel(link_i.first, lq_reg.map_sync,
                                                  lq_reg.dep_sync);
            lq_next.cap.second = dppi_decode_pixel(link_i.second, lq_reg.map_sync,
                                                   lq_reg.dep_sync);
        end
        // A stream cannot be stalled, so a full FIFO loses the pair and is flagged.
        lq_next.ovf = lq_reg.ovf | (lq_reg.cap_vld & ~wr_ready);
        lq_next.flt = lq_reg.flt | (|lq_reg.hv_sync);
        if (lk_rst) begin
            lq_next.st = LK_HUNT;
            lq_next.gap = `DPPI_GAP_RESET;
            lq_next.cap_vld = 1'b0;
            lq_next.cap = '0;
            lq_next.ovf = 1'b0;
            lq_next.flt = 1'b0;
        end
    end

    always_ff @(posedge pixel_clock_i) begin
        lq_reg <= lq_next;
    end

    dppi_async_fifo #(
        .WIDTH($bits(dppi_pair_t)),
        .DEPTH(`DPPI_FIFO_DEPTH)
    ) u_fifo (
        .wr_clk_i(pixel_clock_i),
        .wr_rst_i(lk_rst),
        .wr_valid_i(lq_reg.cap_vld),
        .wr_ready_o(wr_ready),
        .wr_data_i(lq_reg.cap),
        .rd_clk_i(clock_i),
        .rd_rst_i(sys_rst_i),
        .rd_valid_o(rd_valid),
        .rd_ready_i(rd_ready),
        .rd_data_o(rd_data)
    );

    // ****************************************************************
    // Core domain: output register and status crossing
    // ****************************************************************
    assign rd_ready = ~cq_reg.valid | out_ready_i;

    always_comb begin
        cq_next = cq_reg;
        cq_next.ovf_meta = lq_reg.ovf;
        cq_next.ovf_sync = cq_reg.ovf_meta;
        cq_next.flt_meta = lq_reg.flt;
        cq_next.flt_sync = cq_reg.flt_meta;
        if (rd_ready) begin
            cq_next.valid = rd_valid;
            if (rd_valid) begin
                cq_next.data = rd_data;
            end
        end
        if (sys_rst_i) begin
            cq_next = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        cq_reg <= cq_next;
    end

    assign out_valid_o = cq_reg.valid;
    assign out_pair_o = cq_reg.data;
    assign overflow_o = cq_reg.ovf_sync;
    assign sync_fault_o = cq_reg.flt_sync;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_pair_capture: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (de && !lq_reg.st[0]) |=> lq_reg.cap_vld)
        else $error("Enabled pixel pair was not captured.");

    chk_enable_only: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.cap_vld |-> $past(de))
        else $error("Pair captured without data enable.");

    chk_first_lane: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.cap_vld |-> lq_reg.cap.first == dppi_decode_pixel($past(link_i.first),
            $past(lq_reg.map_sync), $past(lq_reg.dep_sync)))
        else $error("First lane decoded wrongly.");

    chk_second_lane: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.cap_vld |-> lq_reg.cap.second == dppi_decode_pixel($past(link_i.second),
            $past(lq_reg.map_sync), $past(lq_reg.dep_sync)))
        else $error("Second lane decoded wrongly.");

    chk_first_map_raw: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && !$past(lq_reg.map_sync) && !$past(lq_reg.dep_sync))
        |-> lq_reg.cap.first.blue == $past(link_i.first.blue))
        else $error("First mapping altered the bit order.");

    chk_eight_bit: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && $past(lq_reg.dep_sync))
        |-> lq_reg.cap.second.red[1:0] == lq_reg.cap.second.red[9:8])
        else $error("Eight-bit value not widened.");

    chk_full_scale: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (de && !lq_reg.st[0] && link_i.first.green == 10'h3FF) |=> lq_reg.cap.first.green == 10'h3FF)
        else $error("Brightest code not kept.");

    chk_dark_level: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (de && !lq_reg.st[0] && link_i.second.blue == 10'h000) |=> lq_reg.cap.second.blue == 10'h000)
        else $error("Darkest code not kept.");

    chk_frame_gap: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && lq_reg.cap.frame_start) |-> $past(lq_reg.gap) >= `DPPI_FRAME_GAP)
        else $error("Frame start without a frame gap.");

    chk_frame_first: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && lq_reg.cap.frame_start) |-> lq_reg.cap.line_start)
        else $error("Frame start not on a line start.");

    chk_out_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_pair_o)))
        else $error("Output pair changed while stalled.");

    chk_hunt_drop: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.st[0] |=> !lq_reg.cap_vld)
        else $error("Pair captured while hunting for a frame gap.");

    chk_line_start: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && $past(lq_reg.st[1])) |-> lq_reg.cap.line_start)
        else $error("First pair after blanking not marked as line start.");

    chk_line_after_gap: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && lq_reg.cap.line_start) |-> $past(lq_reg.st[1]))
        else $error("Line start marked inside a line.");

    chk_ovf_flag: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (lq_reg.cap_vld && !wr_ready) |=> lq_reg.ovf)
        else $error("Dropped pair not flagged.");

    chk_fault_flag: assert property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (|lq_reg.hv_sync) |=> lq_reg.flt)
        else $error("Sync input high not flagged.");

    chk_ovf_sticky: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        overflow_o |=> overflow_o)
        else $error("Overflow status cleared without reset.");

    chk_fault_sticky: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        sync_fault_o |=> sync_fault_o)
        else $error("Sync fault status cleared without reset.");

    cov_frame_start: cover property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.cap_vld && lq_reg.cap.frame_start);

    cov_second_map: cover property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.cap_vld && lq_reg.map_sync && !lq_reg.dep_sync);

    cov_overflow: cover property (@(posedge pixel_clock_i) disable iff (lk_rst)
        lq_reg.cap_vld && !wr_ready);

    cov_sync_fault: cover property (@(posedge pixel_clock_i) disable iff (lk_rst)
        (|lq_reg.hv_sync) && lq_reg.cap_vld);

    cov_out_stall: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        out_valid_o && !out_ready_i ##1 out_valid_o && out_ready_i);
endmodule

// File: logic/dppi_defines.svh
// Constants of the dual-pixel panel input receiver.
// Functional notes
// - Every pixel clock brings two pixels in parallel and both are captured on that same edge.
// - The first pixel of a frame is odd and rides the first lane; the even pixel rides the second.
// - The first lane carries 10-bit red, green and blue, bit 9 most and bit 0 least significant.
// - The second lane carries its own 10-bit red, green and blue with the same bit order.
// - Each component is an unsigned intensity, zero darkest, all ones brightest, monotonic.
// - A data bit at the high level decodes as one and at the low level as zero.
// - Mapping strap low or open selects the first standard mapping, high selects the second.
// - A data-enable qualifier and a data clock travel with the pixels; data counts only under enable.
// - Lines and frames are found from the data enable alone, never from the sync inputs.
// - Depth strap high (default) selects 8-bit components and low selects 10-bit components.
`ifndef DPPI_DEFINES_SVH
`define DPPI_DEFINES_SVH

`define DPPI_COMP_W 10
`define DPPI_FIFO_DEPTH 16
`define DPPI_GAP_W 12
`define DPPI_GAP_RESET 12'h000
`define DPPI_GAP_MAX 12'hFFF
// Enable-low run of at least 400 clocks, longer than any line blanking, marks a frame gap.
`define DPPI_FRAME_GAP 12'h190

`endif

// File: logic/dppi_pkg.sv
// Types and pixel decode functions of the dual-pixel panel input receiver.
package dppi_pkg;

    typedef struct packed {
        logic [9:0] red;
        logic [9:0] green;
        logic [9:0] blue;
    } dppi_pixel_t;

    typedef struct packed {
        dppi_pixel_t first;
        dppi_pixel_t second;
        logic pixel_valid;
        logic hsync;
        logic vsync;
    } dppi_link_t;

    typedef struct packed {
        logic frame_start;
        logic line_start;
        dppi_pixel_t first;
        dppi_pixel_t second;
    } dppi_pair_t;

    typedef enum logic [2:0] {
        LK_HUNT = 3'b001,
        LK_BLANK = 3'b010,
        LK_LINE = 3'b100
    } dppi_lk_state_t;

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic map_meta;
        logic map_sync;
        logic dep_meta;
        logic dep_sync;
        logic [1:0] hv_meta;
        logic [1:0] hv_sync;
        dppi_lk_state_t st;
        logic [11:0] gap;
        logic cap_vld;
        dppi_pair_t cap;
        logic ovf;
        logic flt;
    } dppi_link_state_t;

    typedef struct packed {
        logic valid;
        dppi_pair_t data;
        logic ovf_meta;
        logic ovf_sync;
        logic flt_meta;
        logic flt_sync;
    } dppi_core_state_t;

    // Lane positions arrive as {pair 4, pair 3, six main bits}; the second mapping
    // carries the most significant bits on the main channels.
    function automatic logic [9:0] dppi_decode(input logic [9:0] raw, input logic second_map,
                                               input logic eight_bit);
        logic [9:0] v10;
        logic [7:0] v8;
        v10 = second_map ? {raw[5:0], raw[7:6], raw[9:8]} : raw;
        v8 = second_map ? {raw[5:0], raw[7:6]} : raw[7:0];
        return eight_bit ? {v8, v8[7:6]} : v10;
    endfunction

    function automatic dppi_pixel_t dppi_decode_pixel(input dppi_pixel_t p, input logic second_map,
                                                      input logic eight_bit);
        dppi_pixel_t r;
        r.red = dppi_decode(p.red, second_map, eight_bit);
        r.green = dppi_decode(p.green, second_map, eight_bit);
        r.blue = dppi_decode(p.blue, second_map, eight_bit);
        return r;
    endfunction

endpackage

// File: verification/dppi_tx_model.sv
// Behavioural transmitter that drives the dual-pixel link.
`timescale 1ns/1ns
`include "dppi_defines.svh"

// ****************************************
// Transmitter model
// ****************************************
module dppi_tx_model (
    // Link clock
    input wire logic pixel_clock_i,
    // Link to the receiver
    output dppi_pkg::dppi_link_t link_o
);
    import dppi_pkg::*;

    dppi_pair_t sent_q[$];
    logic rec = 1'b1;
    logic hv_noise = 1'b0;
    logic pend_line = 1'b0;
    logic pend_frame = 1'b0;

    initial begin
        link_o = '0;
    end

    function automatic dppi_pixel_t rnd_pix();
        logic [31:0] r;
        r = $urandom;
        return r[29:0];
    endfunction

    // Drives one pixel clock of the link just after the rising edge.
    task automatic step(input logic vld, input dppi_pixel_t a, input dppi_pixel_t b);
        logic [31:0] r;
        r = $urandom;
        @(posedge pixel_clock_i);
        #1;
        link_o.pixel_valid = vld;
        link_o.first = a;
        link_o.second = b;
        link_o.hsync = hv_noise & r[0];
        link_o.vsync = hv_noise & r[1];
    endtask

    // The first blanking lane inverts every clock and the second is random, so stale data cannot pass for valid data.
    task automatic idle(input int n);
        repeat (n) begin
            step(1'b0, ~link_o.first, rnd_pix());
        end
        pend_line = 1'b1;
        pend_frame = (n >= `DPPI_FRAME_GAP);
    endtask

    task automatic pair(input dppi_pixel_t a, input dppi_pixel_t b);
        step(1'b1, a, b);
        if (rec) begin
            sent_q.push_back({pend_frame, pend_line, a, b});
        end
        pend_line = 1'b0;
        pend_frame = 1'b0;
    endtask
endmodule

// File: verification/tb.sv
// Self-checking bench of the dual-pixel panel input receiver.
`timescale 1ns/1ns

// ****************************************
// Bench top
// ****************************************
module tb;
    import dppi_pkg::*;

    localparam int RST_CYC = 40;
    localparam int LIMIT = 90000;

    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic pixel_clock_i = 1'b0;
    logic map_s = 1'b0;
    logic dep_s = 1'b0;
    logic stall = 1'b0;
    logic out_ready_i = 1'b0;
    logic out_valid_o;
    logic overflow_o;
    logic sync_fault_o;
    dppi_link_t link;
    dppi_pair_t out_pair_o;
    int error_cnt = 0;
    int checked = 0;
    int drained = 0;
    int cyc = 0;

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        #7;
        forever #32 pixel_clock_i = ~pixel_clock_i;
    end

    dppi_tx_model i_dppi_tx_model (.pixel_clock_i(pixel_clock_i), .link_o(link));

    dppi_rx i_dppi_rx (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .pixel_clock_i(pixel_clock_i),
        .link_i(link), .bit_map_select_i(map_s), .depth_select_i(dep_s),
        .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_pair_o(out_pair_o),
        .overflow_o(overflow_o), .sync_fault_o(sync_fault_o));

    task automatic fail(input string msg);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) fail(what);
    endtask

    task automatic cmp_pair(input dppi_pair_t got, input dppi_pair_t exp);
        checked++;
        if (got !== exp) fail($sformatf("pair %h expected %h", got, exp));
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [9:0] exp_comp(input logic [9:0] r);
        logic [7:0] v8;
        v8 = map_s ? {r[5:0], r[7:6]} : r[7:0];
        if (dep_s) begin
            return {v8, v8[7:6]};
        end
        return map_s ? {r[5:0], r[7:6], r[9:8]} : r;
    endfunction

    function automatic dppi_pixel_t exp_pix(input dppi_pixel_t p);
        return {exp_comp(p.red), exp_comp(p.green), exp_comp(p.blue)};
    endfunction

    function automatic dppi_pair_t exp_pair(input dppi_pair_t s);
        return {s.frame_start, s.line_start, exp_pix(s.first), exp_pix(s.second)};
    endfunction

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail("timeout");
            final_report();
        end
    end

    always @(posedge clock_i) begin
        #1;
        out_ready_i = !stall && ($urandom_range(3) != 0);
    end

    always @(posedge clock_i) begin
        if (!sys_rst_i && out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            if (!i_dppi_tx_model.rec) begin
                drained++;
            end else if (i_dppi_tx_model.sent_q.size() == 0) begin
                fail("unexpected pair");
            end else begin
                cmp_pair(out_pair_o, exp_pair(i_dppi_tx_model.sent_q.pop_front()));
            end
        end
    end

    task automatic do_reset();
        sys_rst_i = 1'b1;
        repeat (RST_CYC) @(posedge clock_i);
        #1;
        sys_rst_i = 1'b0;
        cmp_bit(out_valid_o, 1'b0, "valid after reset");
        cmp_pair(out_pair_o, '0);
        cmp_bit(overflow_o, 1'b0, "overflow after reset");
        cmp_bit(sync_fault_o, 1'b0, "fault after reset");
        repeat (6) @(posedge pixel_clock_i);
    endtask

    // Walking ones and their inverse expose any swapped or mirrored bit.
    task automatic frame(input int lines);
        i_dppi_tx_model.idle(450);
        for (int k = 0; k < 10; k++) begin
            i_dppi_tx_model.pair({3{10'h001 << k}}, {3{~(10'h001 << k)}});
        end
        i_dppi_tx_model.pair('0, '1);
        for (int l = 0; l < lines; l++) begin
            i_dppi_tx_model.idle(l[0] ? 190 : 90);
            repeat (12) i_dppi_tx_model.pair(i_dppi_tx_model.rnd_pix(), i_dppi_tx_model.rnd_pix());
        end
        i_dppi_tx_model.idle(8);
    endtask

    task automatic wait_empty();
        int n;
        n = 0;
        while ((i_dppi_tx_model.sent_q.size() != 0 || out_valid_o === 1'b1) && n < 3000) begin
            @(posedge clock_i);
            n++;
        end
        cmp_bit(n < 3000, 1'b1, "stream did not drain");
    endtask

    initial begin
        void'($urandom(32'h4fc6));
        for (int c = 0; c < 4; c++) begin
            map_s = c[0];
            dep_s = c[1];
            do_reset();
            i_dppi_tx_model.rec = 1'b0;
            repeat (5) i_dppi_tx_model.pair(i_dppi_tx_model.rnd_pix(), i_dppi_tx_model.rnd_pix());
            i_dppi_tx_model.rec = 1'b1;
            frame(3);
            wait_empty();
        end
        cmp_bit(sync_fault_o, 1'b0, "fault without sync");
        stall = 1'b1;
        i_dppi_tx_model.rec = 1'b0;
        i_dppi_tx_model.idle(450);
        repeat (40) i_dppi_tx_model.pair(i_dppi_tx_model.rnd_pix(), i_dppi_tx_model.rnd_pix());
        i_dppi_tx_model.idle(8);
        repeat (20) @(posedge clock_i);
        cmp_bit(overflow_o, 1'b1, "no overflow");
        drained = 0;
        stall = 1'b0;
        wait_empty();
        cmp_bit(drained >= 16 && drained <= 18, 1'b1, "drain count");
        i_dppi_tx_model.rec = 1'b1;
        i_dppi_tx_model.hv_noise = 1'b1;
        frame(2);
        wait_empty();
        cmp_bit(sync_fault_o, 1'b1, "sync not reported");
        final_report();
    end
endmodule
